/* design/gxd_pkg.sv */
// package for the guest exit decision block: register map, control bit
// positions, reset values, request and answer carriers, cause codes.
// assumes a single core clock that ticks at the timestamp counter rate.
package gxd_pkg;

  // register byte addresses on the plain register port
  localparam logic [12:0] GXD_OFF_PRIMARY = 13'h0000;
  localparam logic [12:0] GXD_OFF_SECONDARY = 13'h0004;
  localparam logic [12:0] GXD_OFF_GAP = 13'h0008;
  localparam logic [12:0] GXD_OFF_WINDOW = 13'h000C;
  localparam logic [12:0] GXD_OFF_PAGE = 13'h0010;
  localparam logic [12:0] GXD_OFF_THRESHOLD = 13'h0014;
  localparam logic [12:0] GXD_OFF_STATUS = 13'h0018;
  localparam logic [12:0] GXD_OFF_TIME = 13'h001C;
  // bitmap window: 1024 words at 1000H..1FFCH
  localparam logic [12:0] GXD_OFF_BITMAP = 13'h1000;
  localparam int GXD_BM_WORDS = 1024;
  // word bases of the four bitmaps inside the window
  localparam logic [9:0] GXD_BM_LOW_READ = 10'h000;
  localparam logic [9:0] GXD_BM_HIGH_READ = 10'h100;
  localparam logic [9:0] GXD_BM_LOW_WRITE = 10'h200;
  localparam logic [9:0] GXD_BM_HIGH_WRITE = 10'h300;

  // primary control bit positions
  localparam int GXD_P_PAUSE_EXIT = 0;
  localparam int GXD_P_PERF_EXIT = 1;
  localparam int GXD_P_TS_EXIT = 2;
  localparam int GXD_P_CR8_LOAD_EXIT = 3;
  localparam int GXD_P_USE_SHADOW = 4;
  localparam int GXD_P_USE_BITMAPS = 5;
  localparam int GXD_P_SECONDARY_ON = 31;
  // secondary control bit positions
  localparam int GXD_S_LOOP_EXIT = 0;
  localparam int GXD_S_RAND_EXIT = 1;
  localparam int GXD_S_TS_ID_ENABLE = 2;
  localparam int GXD_S_WB_EXIT = 3;
  localparam int GXD_S_X2_VIRT = 4;
  localparam int GXD_S_ACCESS_VIRT = 5;
  localparam int GXD_S_NESTED = 6;

  localparam logic [31:0] GXD_RST_PRIMARY = 32'h0000_0000;
  localparam logic [31:0] GXD_RST_SECONDARY = 32'h0000_0000;
  localparam logic [31:0] GXD_RST_GAP = 32'h0000_0000;
  localparam logic [31:0] GXD_RST_WINDOW = 32'h0000_0000;
  localparam logic [19:0] GXD_RST_PAGE = 20'h0_0000;
  localparam logic [3:0] GXD_RST_THRESHOLD = 4'h0;

  // model register index ranges and the priority register index
  localparam logic [31:0] GXD_LOW_FIRST = 32'h0000_0000;
  localparam logic [31:0] GXD_LOW_LAST = 32'h0000_1FFF;
  localparam logic [31:0] GXD_HIGH_FIRST = 32'hC000_0000;
  localparam logic [31:0] GXD_HIGH_LAST = 32'hC000_1FFF;
  localparam logic [31:0] GXD_BIT_MASK = 32'h0000_1FFF;
  localparam logic [31:0] GXD_PRIO_INDEX = 32'h0000_0808;
  // priority field offset in the access page, 16-byte granule
  localparam logic [7:0] GXD_PRIO_FIELD = 8'h08;
  // large translations exit or not: this design chooses not to
  localparam logic GXD_LARGE_EXITS = 1'b0;

  typedef enum logic [3:0] {
    GXD_OP_NONE = 4'h0,
    GXD_OP_PAUSE = 4'h1,
    GXD_OP_MREG_READ = 4'h2,
    GXD_OP_MREG_WRITE = 4'h3,
    GXD_OP_PERF_READ = 4'h4,
    GXD_OP_RAND_READ = 4'h5,
    GXD_OP_TS_READ = 4'h6,
    GXD_OP_TS_ID_READ = 4'h7,
    GXD_OP_RESUME = 4'h8,
    GXD_OP_WB_INVAL = 4'h9,
    GXD_OP_PRIO_CR_WRITE = 4'hA,
    GXD_OP_MEM_ACCESS = 4'hB
  } gxd_op_t;

  typedef enum logic [3:0] {
    GXD_CAUSE_NONE = 4'h0,
    GXD_CAUSE_PAUSE = 4'h1,
    GXD_CAUSE_MREG_READ = 4'h2,
    GXD_CAUSE_MREG_WRITE = 4'h3,
    GXD_CAUSE_PERF_READ = 4'h4,
    GXD_CAUSE_RAND_READ = 4'h5,
    GXD_CAUSE_TS_READ = 4'h6,
    GXD_CAUSE_TS_ID_READ = 4'h7,
    GXD_CAUSE_RESUME = 4'h8,
    GXD_CAUSE_WB_INVAL = 4'h9,
    GXD_CAUSE_PRIO_TRAP = 4'hA,
    GXD_CAUSE_ACCESS_PAGE = 4'hB
  } gxd_cause_t;

  typedef struct packed {
    logic valid;
    gxd_op_t op;
    logic [1:0] current_privilege_level;
    logic system_management_state;
    logic [31:0] model_reg_index;
    logic [3:0] prio_old;
    logic [3:0] prio_new;
    logic [31:0] phys_addr;
    logic linear;
    logic paging_on;
    logic guest_large;
    logic nested_large;
  } gxd_req_t;

  typedef struct packed {
    logic valid;
    logic exit;
    logic trap;
    gxd_cause_t cause;
    logic invalid_opcode;
    logic virt_prio_write;
  } gxd_resp_t;

endpackage : gxd_pkg

/* design/gxd_top.sv */
// guest exit decision: decides per pipeline request whether a guest
// instruction or memory access leaves guest mode, and with which cause.
// assumes the pipeline and register master share clk; requests come from
// same-clock logic, one per cycle at most, answered one cycle later.
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/100ps

module gxd_top
  import gxd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [12:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic vm_entry,
  input gxd_req_t req,
  output gxd_resp_t resp
);

  logic rst_meta_n;
  logic rst_sync_n;

  logic [31:0] primary;
  logic [31:0] secondary;
  logic [31:0] loop_gap_limit;
  logic [31:0] loop_window_limit;
  logic [19:0] access_page;
  logic [3:0] prio_threshold;
  logic [31:0] next_primary;
  logic [31:0] next_secondary;
  logic [31:0] next_loop_gap_limit;
  logic [31:0] next_loop_window_limit;
  logic [19:0] next_access_page;
  logic [3:0] next_prio_threshold;
  logic [31:0] next_reg_rdata;

  logic [31:0] bitmap [0:GXD_BM_WORDS-1];

  logic [31:0] timestamp_counter;
  logic [31:0] last_pause;
  logic [31:0] loop_start;
  logic pause_seen;
  logic [31:0] next_timestamp_counter;
  logic [31:0] next_last_pause;
  logic [31:0] next_loop_start;
  logic next_pause_seen;

  gxd_resp_t next_resp;
  gxd_cause_t last_cause;
  gxd_cause_t next_last_cause;
  logic [15:0] exit_count;
  logic [15:0] next_exit_count;

  // effective controls
  logic sec_on;
  logic c_pause_exit;
  logic c_loop_exit;
  logic c_perf_exit;
  logic c_ts_exit;
  logic c_rand_exit;
  logic c_ts_id;
  logic c_wb_exit;
  logic c_x2_virt;
  logic c_access_virt;
  logic c_nested;
  logic c_cr8_exit;
  logic c_shadow;
  logic c_bitmaps;

  function automatic logic in_range(input logic [31:0] v, input logic [31:0] lo,
                                    input logic [31:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction : in_range

  // pick bit n of the bitmap whose first word is base
  function automatic logic [9:0] bm_word(input logic [9:0] base, input logic [31:0] idx);
    logic [31:0] n;
    n = idx & GXD_BIT_MASK;
    bm_word = base + {2'b00, n[12:5]};
  endfunction : bm_word

  function automatic logic [4:0] bm_bit(input logic [31:0] idx);
    bm_bit = idx[4:0];
  endfunction : bm_bit

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  assign sec_on = primary[GXD_P_SECONDARY_ON];
  assign c_pause_exit = primary[GXD_P_PAUSE_EXIT];
  assign c_perf_exit = primary[GXD_P_PERF_EXIT];
  assign c_ts_exit = primary[GXD_P_TS_EXIT];
  assign c_cr8_exit = primary[GXD_P_CR8_LOAD_EXIT];
  assign c_shadow = primary[GXD_P_USE_SHADOW];
  assign c_bitmaps = primary[GXD_P_USE_BITMAPS];
  assign c_loop_exit = sec_on & secondary[GXD_S_LOOP_EXIT];
  assign c_rand_exit = sec_on & secondary[GXD_S_RAND_EXIT];
  assign c_ts_id = sec_on & secondary[GXD_S_TS_ID_ENABLE];
  assign c_wb_exit = sec_on & secondary[GXD_S_WB_EXIT];
  assign c_x2_virt = sec_on & secondary[GXD_S_X2_VIRT];
  assign c_access_virt = sec_on & secondary[GXD_S_ACCESS_VIRT];
  assign c_nested = sec_on & secondary[GXD_S_NESTED];

  // register file
  always_comb begin
    next_primary = primary;
    next_secondary = secondary;
    next_loop_gap_limit = loop_gap_limit;
    next_loop_window_limit = loop_window_limit;
    next_access_page = access_page;
    next_prio_threshold = prio_threshold;
    next_reg_rdata = 32'h0000_0000;
    if (reg_write) begin
      unique case (reg_addr)
        GXD_OFF_PRIMARY: next_primary = reg_wdata;
        GXD_OFF_SECONDARY: next_secondary = reg_wdata;
        GXD_OFF_GAP: next_loop_gap_limit = reg_wdata;
        GXD_OFF_WINDOW: next_loop_window_limit = reg_wdata;
        GXD_OFF_PAGE: next_access_page = reg_wdata[31:12];
        GXD_OFF_THRESHOLD: next_prio_threshold = reg_wdata[3:0];
        default: ;
      endcase
    end
    if (reg_read) begin
      if (reg_addr[12]) begin
        next_reg_rdata = bitmap[reg_addr[11:2]];
      end else begin
        unique case (reg_addr)
          GXD_OFF_PRIMARY: next_reg_rdata = primary;
          GXD_OFF_SECONDARY: next_reg_rdata = secondary;
          GXD_OFF_GAP: next_reg_rdata = loop_gap_limit;
          GXD_OFF_WINDOW: next_reg_rdata = loop_window_limit;
          GXD_OFF_PAGE: next_reg_rdata = {access_page, 12'h000};
          GXD_OFF_THRESHOLD: next_reg_rdata = {28'h000_0000, prio_threshold};
          GXD_OFF_STATUS: next_reg_rdata = {exit_count, 11'h000, pause_seen, last_cause};
          GXD_OFF_TIME: next_reg_rdata = timestamp_counter;
          default: next_reg_rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      primary <= GXD_RST_PRIMARY;
      secondary <= GXD_RST_SECONDARY;
      loop_gap_limit <= GXD_RST_GAP;
      loop_window_limit <= GXD_RST_WINDOW;
      access_page <= GXD_RST_PAGE;
      prio_threshold <= GXD_RST_THRESHOLD;
      reg_rdata <= 32'h0000_0000;
    end else begin
      primary <= next_primary;
      secondary <= next_secondary;
      loop_gap_limit <= next_loop_gap_limit;
      loop_window_limit <= next_loop_window_limit;
      access_page <= next_access_page;
      prio_threshold <= next_prio_threshold;
      reg_rdata <= next_reg_rdata;
    end
  end

  // bitmaps hold no reset: software loads them before enabling them
  always_ff @(posedge clk) begin
    if (reg_write && reg_addr[12]) begin
      bitmap[reg_addr[11:2]] <= reg_wdata;
    end
  end

  // decision logic
  logic [31:0] gap_time;
  logic [31:0] window_time;
  logic pause_first;
  logic loop_active;
  logic idx_low;
  logic idx_high;
  logic mreg_exit;
  logic prio_lowered;
  logic is_access_page;
  logic eff_large;

  always_comb begin
    logic [9:0] rd_base;
    logic [9:0] wr_base;
    logic rd_bit;
    logic wr_bit;
    rd_base = 10'h000;
    wr_base = 10'h000;
    rd_bit = 1'b0;
    wr_bit = 1'b0;
    next_timestamp_counter = timestamp_counter + 32'h0000_0001;
    next_last_pause = last_pause;
    next_loop_start = loop_start;
    next_pause_seen = pause_seen;
    next_resp = '0;
    next_resp.cause = GXD_CAUSE_NONE;
    next_last_cause = last_cause;
    next_exit_count = exit_count;

    gap_time = timestamp_counter - last_pause;
    window_time = timestamp_counter - loop_start;
    pause_first = !pause_seen || (gap_time > loop_gap_limit);
    loop_active = (req.current_privilege_level == 2'b00) && !c_pause_exit && c_loop_exit;

    idx_low = in_range(req.model_reg_index, GXD_LOW_FIRST, GXD_LOW_LAST);
    idx_high = in_range(req.model_reg_index, GXD_HIGH_FIRST, GXD_HIGH_LAST);
    rd_base = idx_high ? GXD_BM_HIGH_READ : GXD_BM_LOW_READ;
    wr_base = idx_high ? GXD_BM_HIGH_WRITE : GXD_BM_LOW_WRITE;
    rd_bit = bitmap[bm_word(rd_base, req.model_reg_index)][bm_bit(req.model_reg_index)];
    wr_bit = bitmap[bm_word(wr_base, req.model_reg_index)][bm_bit(req.model_reg_index)];
    if (req.op == GXD_OP_MREG_WRITE) begin
      mreg_exit = !c_bitmaps || !(idx_low || idx_high) || wr_bit;
    end else begin
      mreg_exit = !c_bitmaps || !(idx_low || idx_high) || rd_bit;
    end

    // lowered below threshold: new value under threshold and under old value
    prio_lowered = (req.prio_new < prio_threshold) && (req.prio_new < req.prio_old);

    is_access_page = (req.phys_addr[31:12] == access_page);
    if (req.paging_on && c_nested) begin
      eff_large = req.guest_large && req.nested_large;
    end else begin
      eff_large = req.guest_large;
    end

    if (vm_entry) begin
      next_pause_seen = 1'b0;
    end

    if (req.valid) begin
      next_resp.valid = 1'b1;
      unique case (req.op)
        GXD_OP_PAUSE: begin
          if (req.current_privilege_level != 2'b00 || c_pause_exit) begin
            next_resp.exit = c_pause_exit;
          end else if (loop_active) begin
            next_last_pause = timestamp_counter;
            next_pause_seen = 1'b1;
            if (pause_first) begin
              next_loop_start = timestamp_counter;
            end else if (window_time > loop_window_limit) begin
              next_resp.exit = 1'b1;
            end
          end
          if (next_resp.exit) begin
            next_resp.cause = GXD_CAUSE_PAUSE;
          end
        end
        GXD_OP_MREG_READ: begin
          next_resp.exit = mreg_exit;
          next_resp.cause = mreg_exit ? GXD_CAUSE_MREG_READ : GXD_CAUSE_NONE;
        end
        GXD_OP_MREG_WRITE: begin
          if (mreg_exit) begin
            next_resp.exit = 1'b1;
            next_resp.cause = GXD_CAUSE_MREG_WRITE;
          end else if (req.model_reg_index == GXD_PRIO_INDEX && c_x2_virt) begin
            next_resp.virt_prio_write = 1'b1;
            if (prio_lowered) begin
              next_resp.exit = 1'b1;
              next_resp.trap = 1'b1;
              next_resp.cause = GXD_CAUSE_PRIO_TRAP;
            end
          end
        end
        GXD_OP_PERF_READ: begin
          next_resp.exit = c_perf_exit;
          next_resp.cause = c_perf_exit ? GXD_CAUSE_PERF_READ : GXD_CAUSE_NONE;
        end
        GXD_OP_RAND_READ: begin
          next_resp.exit = c_rand_exit;
          next_resp.cause = c_rand_exit ? GXD_CAUSE_RAND_READ : GXD_CAUSE_NONE;
        end
        GXD_OP_TS_READ: begin
          next_resp.exit = c_ts_exit;
          next_resp.cause = c_ts_exit ? GXD_CAUSE_TS_READ : GXD_CAUSE_NONE;
        end
        GXD_OP_TS_ID_READ: begin
          next_resp.exit = c_ts_exit && c_ts_id;
          next_resp.cause = (c_ts_exit && c_ts_id) ? GXD_CAUSE_TS_ID_READ : GXD_CAUSE_NONE;
        end
        GXD_OP_RESUME: begin
          next_resp.exit = req.system_management_state;
          next_resp.invalid_opcode = !req.system_management_state;
          next_resp.cause = req.system_management_state ? GXD_CAUSE_RESUME : GXD_CAUSE_NONE;
        end
        GXD_OP_WB_INVAL: begin
          next_resp.exit = c_wb_exit;
          next_resp.cause = c_wb_exit ? GXD_CAUSE_WB_INVAL : GXD_CAUSE_NONE;
        end
        GXD_OP_PRIO_CR_WRITE: begin
          if (!c_cr8_exit && c_shadow && prio_lowered) begin
            next_resp.exit = 1'b1;
            next_resp.trap = 1'b1;
            next_resp.cause = GXD_CAUSE_PRIO_TRAP;
          end
        end
        GXD_OP_MEM_ACCESS: begin
          // with the shadow in use the priority field is served by it, not by an exit
          if (c_access_virt && is_access_page
              && !(c_shadow && req.phys_addr[11:4] == GXD_PRIO_FIELD)
              && !(req.linear && eff_large && !GXD_LARGE_EXITS)) begin
            next_resp.exit = 1'b1;
            next_resp.cause = GXD_CAUSE_ACCESS_PAGE;
          end
        end
        default: ;
      endcase
      if (next_resp.exit) begin
        next_last_cause = next_resp.cause;
        next_exit_count = exit_count + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      timestamp_counter <= 32'h0000_0000;
      last_pause <= 32'h0000_0000;
      loop_start <= 32'h0000_0000;
      pause_seen <= 1'b0;
      resp <= '0;
      last_cause <= GXD_CAUSE_NONE;
      exit_count <= 16'h0000;
    end else begin
      timestamp_counter <= next_timestamp_counter;
      last_pause <= next_last_pause;
      loop_start <= next_loop_start;
      pause_seen <= next_pause_seen;
      resp <= next_resp;
      last_cause <= next_last_cause;
      exit_count <= next_exit_count;
    end
  end

endmodule : gxd_top

/* dv/gxd_properties.sv */
// checker for the guest exit decision block: answer timing and decisions.
// assumes it is bound to gxd_top and sees only that module's ports.
`timescale 1ns/100ps
module gxd_properties
  import gxd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [12:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic vm_entry,
  input wire gxd_req_t req,
  input wire gxd_resp_t resp
);
  logic [31:0] prim;
  logic [31:0] sec;
  logic [31:0] eff;
  // shadow of the control words so decisions can be predicted here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prim <= GXD_RST_PRIMARY;
      sec <= GXD_RST_SECONDARY;
    end else if (reg_write && reg_addr == GXD_OFF_PRIMARY) begin
      prim <= reg_wdata;
    end else if (reg_write && reg_addr == GXD_OFF_SECONDARY) begin
      sec <= reg_wdata;
    end
  end
  assign eff = prim[GXD_P_SECONDARY_ON] ? sec : 32'h0000_0000;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  function automatic logic is_op(gxd_req_t r, gxd_op_t o);
    return r.valid && r.op == o;
  endfunction : is_op

  answer_delay_a: assert property (req.valid |=> resp.valid)
    else $error("no answer one cycle after request");
  answer_idle_a: assert property (!req.valid |=> resp == '0)
    else $error("answer without a request");
  perf_exit_a: assert property (is_op(req, GXD_OP_PERF_READ)
    |=> resp.exit == $past(prim[GXD_P_PERF_EXIT])) else $error("counter read exit wrong");
  rand_gate_a: assert property (is_op(req, GXD_OP_RAND_READ)
    |=> resp.exit == $past(eff[GXD_S_RAND_EXIT])) else $error("random read exit wrong");
  ts_id_exit_a: assert property (is_op(req, GXD_OP_TS_ID_READ)
    |=> resp.exit == $past(prim[GXD_P_TS_EXIT] & eff[GXD_S_TS_ID_ENABLE]))
    else $error("timestamp id read exit wrong");
  resume_kind_a: assert property (is_op(req, GXD_OP_RESUME)
    |=> resp.exit != resp.invalid_opcode && resp.exit == $past(req.system_management_state))
    else $error("resume handling wrong");
  pause_high_a: assert property (is_op(req, GXD_OP_PAUSE)
    && req.current_privilege_level != 2'h0
    |=> resp.exit == $past(prim[GXD_P_PAUSE_EXIT])) else $error("pause above level 0 wrong");
  bitmap_off_a: assert property (is_op(req, GXD_OP_MREG_READ) && !prim[GXD_P_USE_BITMAPS]
    |=> resp.exit && resp.cause == GXD_CAUSE_MREG_READ) else $error("read not exiting");
  write_range_a: assert property (is_op(req, GXD_OP_MREG_WRITE)
    && req.model_reg_index > GXD_LOW_LAST
    && !(req.model_reg_index inside {[GXD_HIGH_FIRST:GXD_HIGH_LAST]})
    |=> resp.exit && resp.cause == GXD_CAUSE_MREG_WRITE) else $error("out of range write");
  trap_cause_a: assert property (resp.trap
    |-> resp.exit && resp.cause == GXD_CAUSE_PRIO_TRAP && $past(req.prio_new) < $past(req.prio_old))
    else $error("trap exit without lowering");
  cover property (resp.trap);
  cover property (resp.exit && resp.cause == GXD_CAUSE_PAUSE);
  cover property (resp.exit && resp.cause == GXD_CAUSE_ACCESS_PAGE);
endmodule : gxd_properties

bind gxd_top gxd_properties u_props (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .vm_entry(vm_entry), .req(req), .resp(resp));

/* dv/gxd_pipe_model.sv */
// pipeline model: issues one decision request for each go pulse.
// assumes the bench changes cmd and go just after a rising edge.
`timescale 1ns/100ps
module gxd_pipe_model
  import gxd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire gxd_req_t cmd,
  output gxd_req_t req
);
  gxd_req_t next_req;
  // idle fields toggle so the design cannot lean on stale values
  always_comb begin
    next_req = go ? cmd : gxd_req_t'(~req);
    next_req.valid = go;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req <= '0;
    end else begin
      req <= next_req;
    end
  end
endmodule : gxd_pipe_model

/* dv/gxd_top_tb_top.sv */
// testbench for the guest exit decision block: register port and decisions.
// assumes the pipeline model in gxd_pipe_model and the bound checker.
`timescale 1ns/100ps
module gxd_top_tb_top;
  import gxd_pkg::*;
  logic clk;
  logic rst_n;
  logic [12:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [31:0] reg_rdata;
  logic vm_entry;
  logic go;
  gxd_req_t cmd;
  gxd_req_t req;
  gxd_req_t q;
  gxd_resp_t resp;
  int errors;
  int checked;
  logic [31:0] v0;
  logic [31:0] v1;
  localparam gxd_op_t OPS [4] = '{GXD_OP_PERF_READ, GXD_OP_TS_READ, GXD_OP_RAND_READ,
    GXD_OP_WB_INVAL};

  gxd_top DUT (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .vm_entry(vm_entry), .req(req), .resp(resp));
  gxd_pipe_model pipe (.clk(clk), .rst_n(rst_n), .go(go), .cmd(cmd), .req(req));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic [12:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [12:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // one request through the pipeline model, answer checked one cycle later
  task automatic dec(input gxd_op_t op, input logic e, input gxd_cause_t c,
                     input logic t = 1'b0, input logic io = 1'b0, input logic vp = 1'b0);
    gxd_resp_t x;
    x = '{valid: 1'b1, exit: e, trap: t, cause: c, invalid_opcode: io, virt_prio_write: vp};
    q.op = op;
    @(posedge clk);
    cmd <= q;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1 chk("resp", 32'(resp), 32'(x));
  endtask : dec

  task automatic entry();
    @(posedge clk);
    vm_entry <= 1'b1;
    @(posedge clk);
    vm_entry <= 1'b0;
  endtask : entry

  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    report_and_stop();
  end

  initial begin
    rst_n = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    vm_entry = 1'b0;
    go = 1'b0;
    cmd = '0;
    errors = 0;
    checked = 0;
    q = '0;
    q.valid = 1'b1;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (OPS[i]) begin
      rd(GXD_OFF_PRIMARY + 13'(4 * i), v0);
      chk("reset value", v0, 32'h0000_0000);
    end
    wr(13'h0020, 32'hFFFF_FFFF);
    rd(13'h0020, v0);
    chk("unmapped", v0, 32'h0000_0000);
    // secondary exits set, but ignored while primary bit 31 is clear
    wr(GXD_OFF_SECONDARY, 32'h0000_000A);
    foreach (OPS[i]) dec(OPS[i], 1'b0, GXD_CAUSE_NONE);
    dec(GXD_OP_NONE, 1'b0, GXD_CAUSE_NONE);
    wr(GXD_OFF_PRIMARY, 32'h8000_0006);
    foreach (OPS[i]) dec(OPS[i], 1'b1, gxd_cause_t'(OPS[i]));
    dec(GXD_OP_TS_ID_READ, 1'b0, GXD_CAUSE_NONE);
    wr(GXD_OFF_SECONDARY, 32'h0000_0004);
    dec(GXD_OP_TS_ID_READ, 1'b1, GXD_CAUSE_TS_ID_READ);
    q.system_management_state = 1'b1;
    dec(GXD_OP_RESUME, 1'b1, GXD_CAUSE_RESUME);
    q.system_management_state = 1'b0;
    dec(GXD_OP_RESUME, 1'b0, GXD_CAUSE_NONE, 1'b0, 1'b1);
    q.current_privilege_level = 2'h3;
    dec(GXD_OP_PAUSE, 1'b0, GXD_CAUSE_NONE);
    wr(GXD_OFF_PRIMARY, 32'h8000_0007);
    dec(GXD_OP_PAUSE, 1'b1, GXD_CAUSE_PAUSE);
    q.model_reg_index = 32'h0000_0010;
    dec(GXD_OP_MREG_READ, 1'b1, GXD_CAUSE_MREG_READ);
    // bitmaps have no reset, so every word touched below is written first
    wr(GXD_OFF_BITMAP, 32'h0001_0000);
    wr(13'h1404, 32'h0000_0020);
    wr(13'h1900, 32'h0000_0000);
    wr(13'h1C04, 32'h0000_0020);
    wr(GXD_OFF_THRESHOLD, 32'h0000_0005);
    wr(GXD_OFF_SECONDARY, 32'h0000_0010);
    wr(GXD_OFF_PRIMARY, 32'h8000_0036);
    dec(GXD_OP_MREG_READ, 1'b1, GXD_CAUSE_MREG_READ);
    q.model_reg_index = 32'h0000_0011;
    dec(GXD_OP_MREG_READ, 1'b0, GXD_CAUSE_NONE);
    q.model_reg_index = 32'hC000_0025;
    dec(GXD_OP_MREG_READ, 1'b1, GXD_CAUSE_MREG_READ);
    dec(GXD_OP_MREG_WRITE, 1'b1, GXD_CAUSE_MREG_WRITE);
    q.model_reg_index = 32'hC000_0024;
    dec(GXD_OP_MREG_READ, 1'b0, GXD_CAUSE_NONE);
    q.model_reg_index = 32'h0000_2000;
    dec(GXD_OP_MREG_READ, 1'b1, GXD_CAUSE_MREG_READ);
    q.model_reg_index = 32'hC000_2000;
    dec(GXD_OP_MREG_WRITE, 1'b1, GXD_CAUSE_MREG_WRITE);
    q.model_reg_index = GXD_PRIO_INDEX;
    q.prio_old = 4'h7;
    q.prio_new = 4'h6;
    dec(GXD_OP_MREG_WRITE, 1'b0, GXD_CAUSE_NONE, 1'b0, 1'b0, 1'b1);
    dec(GXD_OP_PRIO_CR_WRITE, 1'b0, GXD_CAUSE_NONE);
    q.prio_new = 4'h3;
    dec(GXD_OP_MREG_WRITE, 1'b1, GXD_CAUSE_PRIO_TRAP, 1'b1, 1'b0, 1'b1);
    dec(GXD_OP_PRIO_CR_WRITE, 1'b1, GXD_CAUSE_PRIO_TRAP, 1'b1);
    // load exiting set: the lowering write must not trap
    wr(GXD_OFF_PRIMARY, 32'h8000_003E);
    dec(GXD_OP_PRIO_CR_WRITE, 1'b0, GXD_CAUSE_NONE);
    wr(GXD_OFF_PRIMARY, 32'h8000_0036);
    q.prio_old = 4'h2;
    dec(GXD_OP_PRIO_CR_WRITE, 1'b0, GXD_CAUSE_NONE);
    wr(13'h1900, 32'h0000_0100);
    dec(GXD_OP_MREG_WRITE, 1'b1, GXD_CAUSE_MREG_WRITE);
    wr(GXD_OFF_PAGE, 32'h0ABC_D000);
    wr(GXD_OFF_SECONDARY, 32'h0000_0071);
    q.phys_addr = 32'h0ABC_D100;
    dec(GXD_OP_MEM_ACCESS, 1'b1, GXD_CAUSE_ACCESS_PAGE);
    q.phys_addr = 32'h0ABC_E100;
    dec(GXD_OP_MEM_ACCESS, 1'b0, GXD_CAUSE_NONE);
    q.phys_addr = 32'h0ABC_D080;
    dec(GXD_OP_MEM_ACCESS, 1'b0, GXD_CAUSE_NONE);
    q.phys_addr = 32'h0ABC_D100;
    q.linear = 1'b1;
    q.paging_on = 1'b1;
    q.guest_large = 1'b1;
    dec(GXD_OP_MEM_ACCESS, 1'b1, GXD_CAUSE_ACCESS_PAGE);
    q.nested_large = 1'b1;
    dec(GXD_OP_MEM_ACCESS, GXD_LARGE_EXITS,
        GXD_LARGE_EXITS ? GXD_CAUSE_ACCESS_PAGE : GXD_CAUSE_NONE);
    // pause loop: requests three cycles apart, window boundary at 21
    wr(GXD_OFF_GAP, 32'h0000_0064);
    wr(GXD_OFF_WINDOW, 32'h0000_0015);
    wr(GXD_OFF_PRIMARY, 32'h8000_0036);
    q.current_privilege_level = 2'h0;
    entry();
    for (int i = 0; i < 9; i++) begin
      dec(GXD_OP_PAUSE, i == 8, i == 8 ? GXD_CAUSE_PAUSE : GXD_CAUSE_NONE);
    end
    repeat (110) @(posedge clk);
    dec(GXD_OP_PAUSE, 1'b0, GXD_CAUSE_NONE);
    repeat (30) @(posedge clk);
    dec(GXD_OP_PAUSE, 1'b1, GXD_CAUSE_PAUSE);
    entry();
    dec(GXD_OP_PAUSE, 1'b0, GXD_CAUSE_NONE);
    rd(GXD_OFF_TIME, v0);
    rd(GXD_OFF_TIME, v1);
    chk("time step", v1 - v0, 32'h0000_0002);
    // twenty exits so far, last one a pause, loop seen after the last entry
    rd(GXD_OFF_STATUS, v0);
    chk("status", v0, 32'h0014_0011);
    @(posedge clk);
    #1 chk("read data idle", reg_rdata, 32'h0000_0000);
    rd(GXD_OFF_PAGE, v0);
    chk("page", v0, 32'h0ABC_D000);
    rd(GXD_OFF_THRESHOLD, v0);
    chk("threshold", v0, 32'h0000_0005);
    report_and_stop();
  end
endmodule : gxd_top_tb_top
